// ---- verilog/ddrps_regs.svh ----
// register offsets, fields, reset values and timing counts of the ddr pad and startup port
`ifndef DDRPS_REGS_SVH
`define DDRPS_REGS_SVH

`define DDRPS_CTRL_ADDR 8'h00
`define DDRPS_STAT_ADDR 8'h04
`define DDRPS_CMD_ADDR 8'h08
`define DDRPS_ADDR_ADDR 8'h0C
`define DDRPS_WDATA_ADDR 8'h10
`define DDRPS_RDATA_ADDR 8'h14
`define DDRPS_MASK_ADDR 8'h18

`define DDRPS_CTRL_START_BIT 0
`define DDRPS_CTRL_SEQRST_BIT 1
`define DDRPS_CTRL_MRST_BIT 2
`define DDRPS_CTRL_CKE_BIT 3
`define DDRPS_CTRL_TYPE_LSB 4
`define DDRPS_CTRL_WIDE_BIT 6

`define DDRPS_CTRL_RESET 32'h0000_0002

`define DDRPS_STAT_DONE_BIT 0
`define DDRPS_STAT_BUSY_BIT 1
`define DDRPS_STAT_LINKBUSY_BIT 2

`define DDRPS_CFG_STEPS 8'h10
`define DDRPS_ODT_PRE 4'h2
`define DDRPS_ODT_POST 4'h2
`define DDRPS_BURST_BEATS 4'h4

`endif

// ---- verilog/ddrps_pkg.sv ----
// types shared by the ddr pad and startup port
package ddrps_pkg;
	typedef enum logic [1:0] {
		DDRPS_DDR3 = 2'b00,
		DDRPS_LPDDR2 = 2'b01,
		DDRPS_LPDDR3 = 2'b10
	} ddrps_mem_type;
	typedef enum logic [2:0] {
		DDRPS_ST_IDLE = 3'b000,
		DDRPS_ST_PRE = 3'b001,
		DDRPS_ST_CMD = 3'b010,
		DDRPS_ST_DATA = 3'b011,
		DDRPS_ST_POST = 3'b100
	} ddrps_phy_state_type;
	typedef enum logic [1:0] {
		DDRPS_SQ_HOLD = 2'b00,
		DDRPS_SQ_WAIT = 2'b01,
		DDRPS_SQ_RUN = 2'b10,
		DDRPS_SQ_DONE = 2'b11
	} ddrps_seq_state_type;
	typedef enum logic [1:0] {
		DDRPS_OP_NOP = 2'b00,
		DDRPS_OP_WRITE = 2'b01,
		DDRPS_OP_READ = 2'b10,
		DDRPS_OP_ACT = 2'b11
	} ddrps_op_type;
endpackage

// ---- verilog/ddrps_phy.sv ----
// link-side pad engine of the ddr pad and startup port, on the phy fast clock
`timescale 1ns/100ps
`include "ddrps_regs.svh"
module ddrps_phy #(
	parameter int DQ_BITS = 32,
	parameter int LANES = 4
) (
	// link clock and reset
	input wire logic phy_fast_clock,
	input wire logic phy_rst_i,
	// request from the control domain; only go_i is synchronised, the operands are held stable while a command is pending
	input wire logic go_i,
	input wire ddrps_pkg::ddrps_op_type op_i,
	input wire ddrps_pkg::ddrps_mem_type mem_type_i,
	input wire logic [15:0] addr_i,
	input wire logic [2:0] bank_i,
	input wire logic [DQ_BITS-1:0] wdata_i,
	input wire logic [LANES-1:0] mask_i,
	input wire logic lane_en_i,
	output logic busy_o,
	output logic [DQ_BITS-1:0] rdata_o,
	// memory command pads
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic cs_n_o,
	output logic [15:0] addr_o,
	output logic [2:0] bank_o,
	output logic mem_termination_ctrl_o,
	// memory data pads
	input wire logic [DQ_BITS-1:0] dq_i,
	output logic [DQ_BITS-1:0] dq_o,
	output logic [DQ_BITS-1:0] dq_oe_o,
	output logic [LANES-1:0] dqs_o,
	output logic [LANES-1:0] dqs_n_o,
	output logic [LANES-1:0] dqs_oe_o,
	output logic [LANES-1:0] mem_byte_mask_o
);
	ddrps_pkg::ddrps_phy_state_type st_q, st_d;
	logic [3:0] cnt_q;
	logic drive_q;
	logic read_q;
	logic [DQ_BITS-1:0] lane_mask_w;
	logic is_write_w;
	logic [3:0] pre_w;
	logic [LANES-1:0] lane_sel_w;
	logic is_read_w;
	logic issue_w;

	// upper half of the bus stays idle and undriven in the narrow setting
	genvar g;
	generate
		for (g = 0; g < DQ_BITS; g++) begin : g_lane
			assign lane_mask_w[g] = (g < DQ_BITS / 2) || lane_en_i;
		end
		for (g = 0; g < LANES; g++) begin : g_strobe
			assign lane_sel_w[g] = (g < LANES / 2) || lane_en_i;
		end
	endgenerate

	assign is_write_w = (op_i == ddrps_pkg::DDRPS_OP_WRITE);
	assign is_read_w = (op_i == ddrps_pkg::DDRPS_OP_READ);
	// a nop still walks the states so the completion handshake closes, but puts nothing on the pads
	assign issue_w = (st_q == ddrps_pkg::DDRPS_ST_CMD) && (op_i != ddrps_pkg::DDRPS_OP_NOP);
	// lpddr2 has no odt pin worth using, so termination lead is skipped
	assign pre_w = (mem_type_i == ddrps_pkg::DDRPS_LPDDR2) ? 4'h0 : `DDRPS_ODT_PRE;
	assign busy_o = (st_q != ddrps_pkg::DDRPS_ST_IDLE);
	assign dq_oe_o = drive_q ? lane_mask_w : '0;
	assign dqs_oe_o = drive_q ? lane_sel_w : '0;
	assign dqs_n_o = ~dqs_o;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ddrps_pkg::DDRPS_ST_IDLE: if (go_i) st_d = ddrps_pkg::DDRPS_ST_PRE;
			ddrps_pkg::DDRPS_ST_PRE: if (cnt_q >= pre_w) st_d = ddrps_pkg::DDRPS_ST_CMD;
			ddrps_pkg::DDRPS_ST_CMD: st_d = (op_i == ddrps_pkg::DDRPS_OP_ACT) ?
				ddrps_pkg::DDRPS_ST_POST : ddrps_pkg::DDRPS_ST_DATA;
			ddrps_pkg::DDRPS_ST_DATA: if (cnt_q == `DDRPS_BURST_BEATS) st_d = ddrps_pkg::DDRPS_ST_POST;
			ddrps_pkg::DDRPS_ST_POST: if (cnt_q == `DDRPS_ODT_POST) st_d = ddrps_pkg::DDRPS_ST_IDLE;
			default: st_d = ddrps_pkg::DDRPS_ST_IDLE;
		endcase
	end

	always_ff @(posedge phy_fast_clock) begin
		if (phy_rst_i) begin
			st_q <= ddrps_pkg::DDRPS_ST_IDLE;
			cnt_q <= 4'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= (st_d != st_q) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	always_ff @(posedge phy_fast_clock) begin
		if (phy_rst_i) begin
			{ras_n_o, cas_n_o, we_n_o, cs_n_o} <= 4'hF;
			addr_o <= 16'h0000;
			bank_o <= 3'h0;
			mem_termination_ctrl_o <= 1'b0;
			drive_q <= 1'b0;
			read_q <= 1'b0;
			dq_o <= '0;
			dqs_o <= '0;
			mem_byte_mask_o <= '0;
			rdata_o <= '0;
		end else begin
			// command issued as active-low strobes for one link cycle
			if (issue_w) begin
				cs_n_o <= 1'b0;
				ras_n_o <= (op_i != ddrps_pkg::DDRPS_OP_ACT);
				cas_n_o <= (op_i == ddrps_pkg::DDRPS_OP_ACT);
				we_n_o <= !is_write_w;
				addr_o <= addr_i;
				bank_o <= bank_i;
			end else begin
				{ras_n_o, cas_n_o, we_n_o, cs_n_o} <= 4'hF;
			end
			// termination covers the whole data phase with lead and tail, except with lpddr2, where it stays off
			mem_termination_ctrl_o <= (st_d != ddrps_pkg::DDRPS_ST_IDLE) &&
				(is_write_w || is_read_w) &&
				(mem_type_i != ddrps_pkg::DDRPS_LPDDR2);
			drive_q <= (st_d == ddrps_pkg::DDRPS_ST_DATA) && is_write_w;
			read_q <= (st_q == ddrps_pkg::DDRPS_ST_DATA) && is_read_w;
			dq_o <= wdata_i;
			dqs_o <= ((st_d == ddrps_pkg::DDRPS_ST_DATA) && is_write_w) ? ~dqs_o & '1 : '0;
			mem_byte_mask_o <= is_write_w ? (mask_i & lane_sel_w) : '0;
			if (read_q)
				rdata_o <= dq_i & lane_mask_w;
		end
	end
endmodule // ddrps_phy

// ---- verilog/ddrps_top.sv ----
// control domain of the ddr pad and startup port: wishbone registers, sequencer, crossings
//
// Notes on behaviour
// - the startup sequencer is held in reset while its reset input, control bit 1 or master reset is active, and leaves it when all are clear.
// - the sequencer starts configuring the memory interface when its start input rises while it waits, or when control bit 0 is written as one.
// - data pads are driven during writes and released during reads.
// - the data bus width follows the dq width setting, top bit 15 or 31.
// - strobe pairs are driven on writes, two pairs narrow and four pairs wide.
// - byte masks are active high, one per lane, two or four lanes.
// - the memory clock pair is the link clock itself, same frequency and phase.
// - row, column, write and chip-select strobes are active low.
// - a 16-bit address and 3-bit bank go to the memory.
// - clock enable is active high and memory reset is active low.
// - exactly one memory type is selected; only lpddr2 changes command timing, by skipping the termination lead.
`timescale 1ns/100ps
`include "ddrps_regs.svh"
module ddrps_top #(
	parameter int DQ_BITS = 32,
	parameter int LANES = 4
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// startup sequencer and master reset pins
	input wire logic startup_sequencer_reset_i,
	input wire logic startup_sequencer_start_i,
	input wire logic mem_master_rst_n_i,
	output logic seq_done_o,
	// serial configuration port
	input wire logic cfg_serial_clk_i,
	input wire logic cfg_serial_data_i,
	output logic cfg_serial_data_o,
	output logic cfg_serial_data_drive_en_o,
	// link clock
	input wire logic phy_fast_clock,
	// memory pads
	output logic mem_clock_p_o,
	output logic mem_clock_n_o,
	output logic mem_cke_o,
	output logic mem_rst_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic cs_n_o,
	output logic [15:0] mem_addr_o,
	output logic [2:0] mem_bank_o,
	output logic mem_termination_ctrl_o,
	input wire logic [DQ_BITS-1:0] dq_i,
	output logic [DQ_BITS-1:0] dq_o,
	output logic [DQ_BITS-1:0] dq_oe_o,
	output logic [LANES-1:0] dqs_o,
	output logic [LANES-1:0] dqs_n_o,
	output logic [LANES-1:0] dqs_oe_o,
	output logic [LANES-1:0] mem_byte_mask_o
);
	// ==========================================================
	// pin synchronisers
	logic [1:0] srst_s, sstart_s, mrst_s, scl_s, sda_s;
	always_ff @(posedge clk_i) begin
		srst_s <= {srst_s[0], startup_sequencer_reset_i};
		sstart_s <= {sstart_s[0], startup_sequencer_start_i};
		mrst_s <= {mrst_s[0], mem_master_rst_n_i};
		scl_s <= {scl_s[0], cfg_serial_clk_i};
		sda_s <= {sda_s[0], cfg_serial_data_i};
	end
	wire master_rst_w = rst_i || !mrst_s[1];

	// ==========================================================
	// registers
	logic [31:0] ctrl_q, cmd_q, addr_q, wdata_q, mask_q;
	logic ack_q;
	wire req_w = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr_w = req_w && wb_we_i;
	function automatic logic [31:0] ddrps_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			if (sel[i])
				old_v[i*8 +: 8] = new_v[i*8 +: 8];
		return old_v;
	endfunction
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	ddrps_pkg::ddrps_mem_type mem_type_w;
	// an unlisted type code falls back to ddr3 so exactly one type is active
	assign mem_type_w = (ctrl_q[`DDRPS_CTRL_TYPE_LSB +: 2] == 2'b11) ? ddrps_pkg::DDRPS_DDR3 :
		ddrps_pkg::ddrps_mem_type'(ctrl_q[`DDRPS_CTRL_TYPE_LSB +: 2]);
	wire wide_w = ctrl_q[`DDRPS_CTRL_WIDE_BIT];

	// ==========================================================
	// startup sequencer
	ddrps_pkg::ddrps_seq_state_type sq_q;
	logic [7:0] step_q;
	logic sstart_d1_q;
	wire seq_reset_w = srst_s[1] || ctrl_q[`DDRPS_CTRL_SEQRST_BIT] || master_rst_w;
	wire start_w = (sstart_s[1] && !sstart_d1_q) || (wr_w && hit(wb_adr_i, `DDRPS_CTRL_ADDR) &&
		wb_sel_i[0] && wb_dat_i[`DDRPS_CTRL_START_BIT]);
	always_ff @(posedge clk_i) begin
		sstart_d1_q <= sstart_s[1];
		if (seq_reset_w) begin
			sq_q <= ddrps_pkg::DDRPS_SQ_HOLD;
			step_q <= 8'h00;
		end else begin
			unique case (sq_q)
				ddrps_pkg::DDRPS_SQ_HOLD: sq_q <= ddrps_pkg::DDRPS_SQ_WAIT;
				ddrps_pkg::DDRPS_SQ_WAIT: if (start_w) sq_q <= ddrps_pkg::DDRPS_SQ_RUN;
				ddrps_pkg::DDRPS_SQ_RUN: begin
					step_q <= step_q + 8'h01;
					if (step_q == `DDRPS_CFG_STEPS - 8'h01)
						sq_q <= ddrps_pkg::DDRPS_SQ_DONE;
				end
				ddrps_pkg::DDRPS_SQ_DONE: sq_q <= ddrps_pkg::DDRPS_SQ_DONE;
			endcase
		end
	end
	assign seq_done_o = (sq_q == ddrps_pkg::DDRPS_SQ_DONE);

	// serial configuration port: open drain, low answer bit during the run
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_serial_data_drive_en_o <= 1'b0;
		else
			cfg_serial_data_drive_en_o <= (sq_q == ddrps_pkg::DDRPS_SQ_RUN) && scl_s[1] &&
				sda_s[1];
	end
	assign cfg_serial_data_o = 1'b0;

	// ==========================================================
	// memory clock, enable and reset
	assign mem_clock_p_o = phy_fast_clock;
	assign mem_clock_n_o = !phy_fast_clock;
	always_ff @(posedge clk_i) begin
		if (master_rst_w) begin
			mem_rst_n_o <= 1'b0;
			mem_cke_o <= 1'b0;
		end else begin
			mem_rst_n_o <= ctrl_q[`DDRPS_CTRL_MRST_BIT];
			mem_cke_o <= ctrl_q[`DDRPS_CTRL_CKE_BIT] && seq_done_o;
		end
	end

	// ==========================================================
	// command crossing: toggle out, toggle back when the link is idle
	logic go_tgl_q, done_s1, done_s2, done_d_q, pending_q;
	logic phy_busy_w, done_tgl_q, go_s1, go_s2, go_d_q, phy_rst_s1, phy_rst_s2;
	logic [DQ_BITS-1:0] rdata_w;
	wire cmd_wr_w = wr_w && hit(wb_adr_i, `DDRPS_CMD_ADDR) && !pending_q && seq_done_o;
	always_ff @(posedge clk_i) begin
		done_s1 <= done_tgl_q;
		done_s2 <= done_s1;
		if (master_rst_w) begin
			go_tgl_q <= 1'b0;
			pending_q <= 1'b0;
			done_d_q <= 1'b0;
		end else begin
			done_d_q <= done_s2;
			if (cmd_wr_w) begin
				go_tgl_q <= !go_tgl_q;
				pending_q <= 1'b1;
			end else if (done_s2 != done_d_q)
				pending_q <= 1'b0;
		end
	end

	// link side: reset, request and completion all cross by two flip-flops
	logic seen_busy_q;
	always_ff @(posedge phy_fast_clock) begin
		phy_rst_s1 <= master_rst_w;
		phy_rst_s2 <= phy_rst_s1;
		go_s1 <= go_tgl_q;
		go_s2 <= go_s1;
		if (phy_rst_s2) begin
			go_d_q <= 1'b0;
			done_tgl_q <= 1'b0;
			seen_busy_q <= 1'b0;
		end else begin
			go_d_q <= go_s2;
			if (phy_busy_w)
				seen_busy_q <= 1'b1;
			else if (seen_busy_q) begin
				seen_busy_q <= 1'b0;
				done_tgl_q <= !done_tgl_q;
			end
		end
	end

	ddrps_phy #(
		.DQ_BITS(DQ_BITS),
		.LANES(LANES)
	) u_phy (
		.phy_fast_clock(phy_fast_clock),
		.phy_rst_i(phy_rst_s2),
		.go_i(go_s2 != go_d_q),
		.op_i(ddrps_pkg::ddrps_op_type'(cmd_q[1:0])),
		.mem_type_i(mem_type_w),
		.addr_i(addr_q[15:0]),
		.bank_i(addr_q[18:16]),
		.wdata_i(wdata_q[DQ_BITS-1:0]),
		.mask_i(mask_q[LANES-1:0]),
		.lane_en_i(wide_w),
		.busy_o(phy_busy_w),
		.rdata_o(rdata_w),
		.ras_n_o(ras_n_o),
		.cas_n_o(cas_n_o),
		.we_n_o(we_n_o),
		.cs_n_o(cs_n_o),
		.addr_o(mem_addr_o),
		.bank_o(mem_bank_o),
		.mem_termination_ctrl_o(mem_termination_ctrl_o),
		.dq_i(dq_i),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_o),
		.dqs_o(dqs_o),
		.dqs_n_o(dqs_n_o),
		.dqs_oe_o(dqs_oe_o),
		.mem_byte_mask_o(mem_byte_mask_o)
	);

	// ==========================================================
	// wishbone register file; operands are frozen while a command is pending
	logic [31:0] rd_w;
	// type and width reach the link domain unsynchronised, so they freeze while a command is in flight
	logic [31:0] ctrl_wr_w;
	assign ctrl_wr_w = ddrps_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_007E;
	assign rd_w = hit(wb_adr_i, `DDRPS_CTRL_ADDR) ? ctrl_q :
		hit(wb_adr_i, `DDRPS_STAT_ADDR) ? {29'h0, pending_q, sq_q == ddrps_pkg::DDRPS_SQ_RUN,
			seq_done_o} :
		hit(wb_adr_i, `DDRPS_CMD_ADDR) ? cmd_q :
		hit(wb_adr_i, `DDRPS_ADDR_ADDR) ? addr_q :
		hit(wb_adr_i, `DDRPS_WDATA_ADDR) ? wdata_q :
		hit(wb_adr_i, `DDRPS_RDATA_ADDR) ? (pending_q ? 32'h0 : 32'(rdata_w)) :
		hit(wb_adr_i, `DDRPS_MASK_ADDR) ? mask_q : 32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `DDRPS_CTRL_RESET;
			cmd_q <= 32'h0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			mask_q <= 32'h0;
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ack_q <= req_w;
			wb_dat_o <= req_w ? rd_w : 32'h0;
			if (wr_w && hit(wb_adr_i, `DDRPS_CTRL_ADDR))
				ctrl_q <= pending_q ? {ctrl_wr_w[31:7], ctrl_q[6:4], ctrl_wr_w[3:0]} : ctrl_wr_w;
			if (cmd_wr_w)
				cmd_q <= ddrps_merge(cmd_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
			if (wr_w && hit(wb_adr_i, `DDRPS_ADDR_ADDR) && !pending_q)
				addr_q <= ddrps_merge(addr_q, wb_dat_i, wb_sel_i) & 32'h0007_FFFF;
			if (wr_w && hit(wb_adr_i, `DDRPS_WDATA_ADDR) && !pending_q)
				wdata_q <= ddrps_merge(wdata_q, wb_dat_i, wb_sel_i);
			if (wr_w && hit(wb_adr_i, `DDRPS_MASK_ADDR) && !pending_q)
				mask_q <= ddrps_merge(mask_q, wb_dat_i, wb_sel_i) & 32'h0000_000F;
		end
	end
	assign wb_ack_o = ack_q;

	// ==========================================================
	// checks
	a_seq_held: assert property (@(posedge clk_i) disable iff (rst_i)
		srst_s[1] |=> sq_q == ddrps_pkg::DDRPS_SQ_HOLD) else $error("sequencer left reset early");
	a_seq_start: assert property (@(posedge clk_i) disable iff (rst_i || seq_reset_w)
		(sq_q == ddrps_pkg::DDRPS_SQ_WAIT && start_w) |=> sq_q == ddrps_pkg::DDRPS_SQ_RUN)
		else $error("start not taken");
	a_no_cmd_early: assert property (@(posedge clk_i) disable iff (rst_i)
		($changed(go_tgl_q) && !$past(master_rst_w)) |-> $past(seq_done_o))
		else $error("command before configuration");
	a_mrst_low: assert property (@(posedge clk_i) disable iff (rst_i)
		!mrst_s[1] |=> !mem_rst_n_o && !mem_cke_o) else $error("memory reset not asserted");
	a_cke_needs_seq: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_cke_o |-> $past(seq_done_o)) else $error("clock enable before setup");
	a_narrow_bus: assert property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		!wide_w |-> dq_oe_o[DQ_BITS-1:DQ_BITS/2] == '0 && dqs_oe_o[LANES-1:LANES/2] == '0)
		else $error("upper lanes driven in narrow mode");
	a_mask_lanes: assert property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		(!wide_w && !$past(wide_w)) |-> mem_byte_mask_o[LANES-1:LANES/2] == '0)
		else $error("mask on idle lanes");
	a_strobe_pair: assert property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		(dqs_n_o == ~dqs_o) && (!dqs_oe_o[0] || dqs_o[0] != $past(dqs_o[0])))
		else $error("strobe pair not complementary or not toggling");
	a_cs_with_cmd: assert property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		(!ras_n_o || !cas_n_o) |-> !cs_n_o) else $error("command without chip select");
	a_odt_lpddr2: assert property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		mem_type_w == ddrps_pkg::DDRPS_LPDDR2 |=> !mem_termination_ctrl_o)
		else $error("termination with lpddr2");
	a_sda_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_serial_data_drive_en_o |-> $past(sq_q) == ddrps_pkg::DDRPS_SQ_RUN)
		else $error("serial line pulled outside run");
	a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	c_seq_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(seq_done_o));
	c_write: cover property (@(posedge phy_fast_clock) disable iff (phy_rst_s2) $rose(dq_oe_o[0]));
	c_read: cover property (@(posedge phy_fast_clock) disable iff (phy_rst_s2)
		!cs_n_o && we_n_o && !cas_n_o);
endmodule // ddrps_top

// ---- test/ddrps_mem_model.sv ----
// partner model of the memory device on the data pads
`timescale 1ns/100ps
module ddrps_mem_model (
	// link clock and command pads
	input wire logic phy_fast_clock,
	input wire logic cs_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	// data pads
	input wire logic [31:0] dq_drv_i,
	input wire logic [31:0] dq_oe_i,
	input wire logic [3:0] mask_i,
	output logic [31:0] dq_ret_o
);
	logic [31:0] store_q = 32'h0000_0000;
	int drive_q = 0;
	initial dq_ret_o = 32'h5A5A_5A5A;
	always @(posedge phy_fast_clock) begin
		for (int b = 0; b < 32; b++) begin
			// a high mask keeps the old byte
			if (dq_oe_i[b] === 1'b1 && mask_i[b/8] === 1'b0)
				store_q[b] <= dq_drv_i[b];
		end
		if (cs_n_i === 1'b0 && cas_n_i === 1'b0 && we_n_i === 1'b1)
			drive_q <= 8;
		else if (drive_q > 0)
			drive_q <= drive_q - 1;
		// the bus holds no stale value outside the read window
		dq_ret_o <= (drive_q > 0) ? store_q : ~dq_ret_o;
	end
endmodule // ddrps_mem_model

// ---- test/tb_ddrps_top.sv ----
// self-checking bench of the ddr pad and startup port
`timescale 1ns/100ps
`include "ddrps_regs.svh"
module tb_ddrps_top;
	logic clk_i = 0;
	logic rst_i = 1;
	logic phy_fast_clock = 0;
	logic wb_cyc_i = 0;
	logic wb_stb_i = 0;
	logic wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q, dq_i, dq_o, dq_oe_o;
	logic wb_ack_o, seq_done_o, sda_o, sda_en, ck_p, ck_n, cke, mrst_n;
	logic ras_n_o, cas_n_o, we_n_o, cs_n_o, odt;
	logic seq_rst = 1;
	logic seq_go = 0;
	logic master_rst_n = 1;
	logic cfg_scl = 1;
	logic sda_seen = 0;
	logic [15:0] mem_addr_o;
	logic [2:0] mem_bank_o;
	logic [3:0] dqs_o, dqs_n_o, dqs_oe_o, mask;
	logic [31:0] oe_seen;
	logic [3:0] dqs_seen;
	int cs_cnt, ras_cnt, we_cnt, odt_cnt, num_errors = 0, num_checks = 0;
	// open-drain line with pull-up
	wire sda_wire = (sda_en === 1'b1) ? 1'b0 : 1'b1;
	initial forever #20 clk_i = ~clk_i;
	// the link clock stands for the pll output at half the data rate
	initial begin
		#7;
		forever #16 phy_fast_clock = ~phy_fast_clock;
	end
	ddrps_top #(.DQ_BITS(32), .LANES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.startup_sequencer_reset_i(seq_rst), .startup_sequencer_start_i(seq_go),
		.mem_master_rst_n_i(master_rst_n), .seq_done_o(seq_done_o),
		.cfg_serial_clk_i(cfg_scl), .cfg_serial_data_i(sda_wire), .cfg_serial_data_o(sda_o),
		.cfg_serial_data_drive_en_o(sda_en), .phy_fast_clock(phy_fast_clock),
		.mem_clock_p_o(ck_p), .mem_clock_n_o(ck_n), .mem_cke_o(cke), .mem_rst_n_o(mrst_n),
		.ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .cs_n_o(cs_n_o),
		.mem_addr_o(mem_addr_o), .mem_bank_o(mem_bank_o), .mem_termination_ctrl_o(odt),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o),
		.dqs_oe_o(dqs_oe_o), .mem_byte_mask_o(mask));
	ddrps_mem_model mem (.phy_fast_clock(phy_fast_clock), .cs_n_i(cs_n_o),
		.cas_n_i(cas_n_o), .we_n_i(we_n_o), .dq_drv_i(dq_o), .dq_oe_i(dq_oe_o),
		.mask_i(mask), .dq_ret_o(dq_i));
	always @(posedge phy_fast_clock) begin
		cs_cnt += (cs_n_o === 1'b0);
		ras_cnt += (ras_n_o === 1'b0);
		we_cnt += (we_n_o === 1'b0);
		odt_cnt += (odt === 1'b1);
		oe_seen |= dq_oe_o;
		dqs_seen |= dqs_oe_o;
		sda_seen |= (sda_en === 1'b1);
	end
	// ==========
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd_q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		wb_we_i <= 0;
		@(posedge clk_i);
	endtask
	task clr;
		cs_cnt = 0;
		ras_cnt = 0;
		we_cnt = 0;
		odt_cnt = 0;
		oe_seen = 0;
		dqs_seen = 0;
	endtask
	task op(input ddrps_pkg::ddrps_op_type code);
		clr;
		wb(1, `DDRPS_CMD_ADDR, {30'h0, code});
		repeat (4) @(posedge clk_i);
		do begin
			wb(0, `DDRPS_STAT_ADDR, 32'h0);
		end while (rd_q[`DDRPS_STAT_LINKBUSY_BIT] !== 1'b0);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// scenarios
	task t_reset_vals;
		wb(0, `DDRPS_CTRL_ADDR, 32'h0);
		chk(rd_q, `DDRPS_CTRL_RESET);
		wb(0, 8'h40, 32'h0);
		chk(rd_q, 32'h0);
		chk({cke, mrst_n, cs_n_o, ras_n_o}, 4'h3);
		chk({sda_o, sda_en}, 2'b00);
		repeat (3) begin
			@(negedge phy_fast_clock);
			#3;
			chk({ck_p, ck_n}, {phy_fast_clock, ~phy_fast_clock});
		end
		@(posedge clk_i);
	endtask
	task t_sequencer;
		wb(1, `DDRPS_CTRL_ADDR, 32'h0000_000C);
		repeat (3) @(posedge clk_i);
		chk({cke, mrst_n}, 2'b01);
		seq_go <= 1;
		repeat (3) @(posedge clk_i);
		seq_go <= 0;
		repeat (30) @(posedge clk_i);
		chk(seq_done_o, 0);
		seq_rst <= 0;
		repeat (5) @(posedge clk_i);
		seq_go <= 1;
		repeat (3) @(posedge clk_i);
		seq_go <= 0;
		wb(0, `DDRPS_STAT_ADDR, 32'h0);
		chk(rd_q[`DDRPS_STAT_BUSY_BIT], 1);
		cfg_scl <= 0;
		repeat (4) @(posedge clk_i);
		chk(sda_en, 0);
		cfg_scl <= 1;
		sda_seen = 0;
		for (int n = 0; n < 40 && seq_done_o !== 1'b1; n++)
			@(posedge clk_i);
		chk(seq_done_o, 1);
		@(posedge clk_i);
		chk({cke, mrst_n, sda_seen}, 3'b111);
	endtask
	task t_access;
		logic [31:0] pat [3] = '{32'hA1B2_C3D4, 32'h5E6F_7081, 32'h92A3_B4C5};
		logic [31:0] expv, keep;
		logic [3:0] msk;
		logic wide;
		expv = 32'h0;
		for (int i = 0; i < 3; i++) begin
			wide = (i != 1);
			msk = (i == 2) ? 4'h5 : 4'h0;
			keep = wide ? 32'hFFFF_FFFF : 32'h0000_FFFF;
			wb(1, `DDRPS_CTRL_ADDR, 32'h0C | (i << 4) | (wide << 6));
			wb(1, `DDRPS_ADDR_ADDR, {13'h0, 3'(i + 5), 16'hF0F0 + 16'(i)});
			wb(1, `DDRPS_WDATA_ADDR, pat[i]);
			wb(1, `DDRPS_MASK_ADDR, {28'h0, msk});
			op(ddrps_pkg::DDRPS_OP_WRITE);
			chk({cs_cnt[3:0], we_cnt[3:0]}, 8'h11);
			chk(oe_seen, keep);
			chk(dqs_seen, wide ? 4'hF : 4'h3);
			chk(odt_cnt > 0, i != 1);
			chk({mem_bank_o, mem_addr_o}, {3'(i + 5), 16'hF0F0 + 16'(i)});
			for (int b = 0; b < 4; b++)
				if (!msk[b] && (wide || b < 2))
					expv[8*b+:8] = pat[i][8*b+:8];
			op(ddrps_pkg::DDRPS_OP_READ);
			chk({cs_cnt[3:0], we_cnt[3:0]}, 8'h10);
			chk(oe_seen | dqs_seen, 32'h0);
			chk(odt_cnt > 0, i != 1);
			wb(0, `DDRPS_RDATA_ADDR, 32'h0);
			chk(rd_q & keep, expv & keep);
		end
	endtask
	task t_commands;
		// the unlisted type code must act as ddr3, termination included
		wb(1, `DDRPS_CTRL_ADDR, 32'h0000_007C);
		op(ddrps_pkg::DDRPS_OP_WRITE);
		chk(odt_cnt > 0, 1);
		op(ddrps_pkg::DDRPS_OP_ACT);
		chk({ras_cnt[3:0], we_cnt[3:0]}, 8'h10);
		op(ddrps_pkg::DDRPS_OP_NOP);
		chk(cs_cnt, 0);
	endtask
	task t_master_reset;
		master_rst_n <= 0;
		repeat (6) @(posedge clk_i);
		chk({mrst_n, seq_done_o}, 2'b00);
		master_rst_n <= 1;
		repeat (5) @(posedge clk_i);
		clr;
		wb(1, `DDRPS_CMD_ADDR, 32'h1);
		repeat (40) @(posedge clk_i);
		chk(cs_cnt, 0);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset_vals;
		t_sequencer;
		t_access;
		t_commands;
		t_master_reset;
		report_and_stop;
	end
	// the run needs about 400 clock cycles
	initial begin
		#400000;
		num_errors++;
		report_and_stop;
	end
endmodule // tb_ddrps_top
